/* File: verilog/pts_pkg.sv */
// package: command codes, bit positions and types of the status bytes
package pts_pkg;

    localparam logic [7:0] PTS_CMD_TEMP_STATUS = 8'h7D;
    localparam logic [7:0] PTS_CMD_CML_STATUS  = 8'h7E;
    localparam logic [7:0] PTS_RESET_BYTE      = 8'h00;

    localparam int PTS_BIT_OT_FAULT   = 7;
    localparam int PTS_BIT_OT_WARN    = 6;
    localparam int PTS_BIT_BAD_CMD    = 7;
    localparam int PTS_BIT_BAD_DATA   = 6;
    localparam int PTS_BIT_PEC        = 5;
    localparam int PTS_BIT_MEMORY     = 4;
    localparam int PTS_BIT_LOGIC_CORE = 3;
    localparam int PTS_BIT_LINK       = 1;

    // writable (supported) bits; all others read zero
    localparam logic [7:0] PTS_TEMP_SUPPORTED = 8'hC0;
    localparam logic [7:0] PTS_CML_SUPPORTED  = 8'hFA;

    // fault events, one-cycle pulses from the detectors
    typedef struct packed {
        logic overtempFault;
        logic overtempWarning;
        logic badCommand;
        logic badPayload;
        logic pecFail;
        logic memoryError;
        logic logicCoreError;
        logic linkError;
        logic backChannelError;
    } pts_event_type;

    // host access, one-cycle strobes with code and data
    typedef struct packed {
        logic       writeByte;
        logic       readByte;
        logic       clearFaults;
        logic [7:0] code;
        logic [7:0] data;
    } pts_host_type;

endpackage : pts_pkg

/* File: verilog/pts_status_regs.sv */
// module: latched temperature and link_error_flag/logic/memory status bytes
`timescale 1ns/10ps
module pts_status_regs (
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire pts_pkg::pts_event_type evt,
    input  wire pts_pkg::pts_host_type  host,
    input  wire logic                  loopFollower,
    input  wire logic [7:0]            tempAlertMask,
    input  wire logic [7:0]            cmlAlertMask,
    output logic [7:0]                 readData,
    output logic                       readValid,
    output logic [7:0]                 tempStatus,
    output logic [7:0]                 cmlStatus,
    output logic                       cmlSummary,
    output logic                       alertRequest
);
    import pts_pkg::*;

    typedef struct packed {
        logic [7:0] temp;
        logic [7:0] cml;
        logic [7:0] rdata;
        logic       rvalid;
        logic       summary;
        logic       alert;
    } pts_state_type;

    pts_state_type state_r;
    pts_state_type state_nxt;

    logic [7:0] tempSet;
    logic [7:0] cmlSet;
    logic [7:0] tempClr;
    logic [7:0] cmlClr;

    // set beats clear, so an event in the clearing cycle survives
    function automatic logic [7:0] pts_update(
        input logic [7:0] cur,
        input logic [7:0] setBits,
        input logic [7:0] clrBits,
        input logic [7:0] supported
    );
        pts_update = ((cur & ~clrBits) | setBits) & supported;
    endfunction : pts_update

    always_comb begin
        tempSet = 8'h00;
        tempSet[PTS_BIT_OT_FAULT] = evt.overtempFault;
        tempSet[PTS_BIT_OT_WARN]  = evt.overtempWarning;
        cmlSet = 8'h00;
        cmlSet[PTS_BIT_BAD_CMD]    = evt.badCommand;
        cmlSet[PTS_BIT_BAD_DATA]   = evt.badPayload;
        cmlSet[PTS_BIT_PEC]        = evt.pecFail;
        cmlSet[PTS_BIT_MEMORY]     = evt.memoryError;
        cmlSet[PTS_BIT_LOGIC_CORE] = evt.logicCoreError;
        // back-channel trouble only counts while acting as loop follower
        cmlSet[PTS_BIT_LINK] = evt.linkError
            | (loopFollower & evt.backChannelError);
        tempClr = 8'h00;
        cmlClr  = 8'h00;
        if (host.clearFaults) begin
            tempClr = 8'hFF;
            cmlClr  = 8'hFF;
        end else if (host.writeByte) begin
            // ones clear, zeros leave alone
            if (host.code == PTS_CMD_TEMP_STATUS) begin
                tempClr = host.data;
            end
            if (host.code == PTS_CMD_CML_STATUS) begin
                cmlClr = host.data;
            end
        end
    end

    always_comb begin
        state_nxt = state_r;
        state_nxt.temp = pts_update(state_r.temp, tempSet, tempClr,
                                    PTS_TEMP_SUPPORTED);
        state_nxt.cml  = pts_update(state_r.cml, cmlSet, cmlClr,
                                    PTS_CML_SUPPORTED);
        state_nxt.summary = |state_nxt.cml;
        // alert tracks the masked flags; mask high suppresses the bit
        state_nxt.alert = |(state_nxt.temp & ~tempAlertMask)
                        | |(state_nxt.cml & ~cmlAlertMask);
        state_nxt.rvalid = host.readByte;
        state_nxt.rdata  = 8'h00;
        if (host.readByte) begin
            unique case (host.code)
                PTS_CMD_TEMP_STATUS: state_nxt.rdata = state_r.temp;
                PTS_CMD_CML_STATUS:  state_nxt.rdata = state_r.cml;
                default:             state_nxt.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_r <= '{temp: PTS_RESET_BYTE, cml: PTS_RESET_BYTE,
                         rdata: 8'h00, rvalid: 1'b0, summary: 1'b0,
                         alert: 1'b0};
        end else begin
            state_r <= state_nxt;
        end
    end

    assign readData     = state_r.rdata;
    assign readValid    = state_r.rvalid;
    assign tempStatus   = state_r.temp;
    assign cmlStatus    = state_r.cml;
    assign cmlSummary   = state_r.summary;
    assign alertRequest = state_r.alert;

    a_fault_sets_temp: assert property (
        @(posedge clk) disable iff (rst)
        evt.overtempFault
        |=> tempStatus[PTS_BIT_OT_FAULT])
        else $error("over-temperature fault not latched");

    a_latch_persists: assert property (
        @(posedge clk) disable iff (rst)
        tempStatus[PTS_BIT_OT_FAULT]
        && !host.clearFaults && !host.writeByte
        |=> tempStatus[PTS_BIT_OT_FAULT])
        else $error("fault flag dropped without clear");

    a_warn_sets_temp: assert property (
        @(posedge clk) disable iff (rst)
        evt.overtempWarning
        |=> tempStatus[PTS_BIT_OT_WARN])
        else $error("over-temperature warning not latched");

    a_warn_latch_holds: assert property (
        @(posedge clk) disable iff (rst)
        tempStatus[PTS_BIT_OT_WARN] && !host.clearFaults
        && !(host.writeByte && host.code == PTS_CMD_TEMP_STATUS
             && host.data[PTS_BIT_OT_WARN])
        |=> tempStatus[PTS_BIT_OT_WARN])
        else $error("warning flag dropped without clear");

    a_temp_unused_zero: assert property (
        @(posedge clk) disable iff (rst)
        tempStatus[5:0] == 6'h00)
        else $error("unsupported temperature bit reads nonzero");

    a_cml_unused_zero: assert property (
        @(posedge clk) disable iff (rst)
        cmlStatus[2] == 1'b0
        && cmlStatus[0] == 1'b0)
        else $error("unsupported link_error_flag bit reads nonzero");

    a_write_no_set: assert property (
        @(posedge clk) disable iff (rst)
        host.writeByte && evt == '0
        |=> (tempStatus & ~$past(tempStatus)) == 8'h00
        && (cmlStatus & ~$past(cmlStatus)) == 8'h00)
        else $error("write set a flag");

    a_write_one_clears: assert property (
        @(posedge clk) disable iff (rst)
        host.writeByte && host.code == PTS_CMD_CML_STATUS
        && host.data[PTS_BIT_BAD_CMD] && !evt.badCommand
        |=> !cmlStatus[PTS_BIT_BAD_CMD])
        else $error("write of one did not clear flag");

    a_temp_write_clears: assert property (
        @(posedge clk) disable iff (rst)
        host.writeByte && host.code == PTS_CMD_TEMP_STATUS
        && host.data == 8'hFF
        && !evt.overtempFault && !evt.overtempWarning
        |=> tempStatus == 8'h00)
        else $error("write of ones left a temperature flag");

    a_set_beats_clear: assert property (
        @(posedge clk) disable iff (rst)
        evt.pecFail && host.writeByte
        && host.code == PTS_CMD_CML_STATUS && host.data[PTS_BIT_PEC]
        |=> cmlStatus[PTS_BIT_PEC])
        else $error("clear beat a same-cycle event");

    a_clear_faults_all: assert property (
        @(posedge clk) disable iff (rst)
        host.clearFaults && evt == '0
        |=> tempStatus == 8'h00 && cmlStatus == 8'h00)
        else $error("clear faults left a flag set");

    a_clear_faults_temp: assert property (
        @(posedge clk) disable iff (rst)
        host.clearFaults
        && !evt.overtempFault && !evt.overtempWarning
        |=> tempStatus == 8'h00)
        else $error("clear faults left a temperature flag");

    a_badcmd_sets_cml: assert property (
        @(posedge clk) disable iff (rst)
        evt.badCommand
        |=> cmlStatus[PTS_BIT_BAD_CMD])
        else $error("invalid command not latched");

    a_baddata_sets_cml: assert property (
        @(posedge clk) disable iff (rst)
        evt.badPayload
        |=> cmlStatus[PTS_BIT_BAD_DATA])
        else $error("invalid data not latched");

    a_pec_sets_cml: assert property (
        @(posedge clk) disable iff (rst)
        evt.pecFail
        |=> cmlStatus[PTS_BIT_PEC])
        else $error("packet error not latched");

    a_memory_sets_cml: assert property (
        @(posedge clk) disable iff (rst)
        evt.memoryError
        |=> cmlStatus[PTS_BIT_MEMORY])
        else $error("memory error not latched");

    a_core_sets_cml: assert property (
        @(posedge clk) disable iff (rst)
        evt.logicCoreError
        |=> cmlStatus[PTS_BIT_LOGIC_CORE])
        else $error("logic core error not latched");

    a_link_sets_cml: assert property (
        @(posedge clk) disable iff (rst)
        evt.linkError
        |=> cmlStatus[PTS_BIT_LINK])
        else $error("communication error not latched");

    a_alert_masked: assert property (
        @(posedge clk) disable iff (rst)
        alertRequest == ((|(tempStatus & ~$past(tempAlertMask)))
        || (|(cmlStatus & ~$past(cmlAlertMask)))))
        else $error("alert disagrees with unmasked flags");

    a_alert_full_mask: assert property (
        @(posedge clk) disable iff (rst)
        tempAlertMask == 8'hFF && cmlAlertMask == 8'hFF
        |=> !alertRequest)
        else $error("alert raised with every flag masked");

    a_alert_from_flag: assert property (
        @(posedge clk) disable iff (rst)
        evt.overtempFault && !tempAlertMask[PTS_BIT_OT_FAULT]
        |=> alertRequest)
        else $error("unmasked fault raised no alert");

    a_follower_backchan: assert property (
        @(posedge clk) disable iff (rst)
        loopFollower && evt.backChannelError
        |=> cmlStatus[PTS_BIT_LINK])
        else $error("back-channel fault not reported");

    a_leader_ignores_bc: assert property (
        @(posedge clk) disable iff (rst)
        !loopFollower && evt.backChannelError && !evt.linkError
        && !cmlStatus[PTS_BIT_LINK]
        |=> !cmlStatus[PTS_BIT_LINK])
        else $error("back-channel fault reported off the loop");

    a_summary_is_or: assert property (
        @(posedge clk) disable iff (rst)
        cmlSummary == (|cmlStatus))
        else $error("summary bit disagrees with flags");

    a_summary_on_fault: assert property (
        @(posedge clk) disable iff (rst)
        evt.memoryError
        |=> cmlSummary)
        else $error("summary bit missed a fault");

    a_summary_clears: assert property (
        @(posedge clk) disable iff (rst)
        host.writeByte && !host.clearFaults
        && host.code == PTS_CMD_CML_STATUS && host.data == 8'hFF
        && !evt.badCommand && !evt.badPayload && !evt.pecFail
        && !evt.memoryError && !evt.logicCoreError
        && !evt.linkError && !evt.backChannelError
        |=> !cmlSummary)
        else $error("summary bit kept after clearing write");

    a_read_returns: assert property (
        @(posedge clk) disable iff (rst)
        host.readByte && host.code == PTS_CMD_TEMP_STATUS
        |=> readValid && readData == $past(tempStatus))
        else $error("read of temperature byte wrong");

    a_read_cml: assert property (
        @(posedge clk) disable iff (rst)
        host.readByte && host.code == PTS_CMD_CML_STATUS
        |=> readValid && readData == $past(cmlStatus))
        else $error("read of link_error_flag byte wrong");

    a_read_other_zero: assert property (
        @(posedge clk) disable iff (rst)
        host.readByte && host.code != PTS_CMD_TEMP_STATUS
        && host.code != PTS_CMD_CML_STATUS
        |=> readValid && readData == 8'h00)
        else $error("read of other code not zero");

    a_read_pulse: assert property (
        @(posedge clk) disable iff (rst)
        !host.readByte
        |=> !readValid && readData == 8'h00)
        else $error("read answer without a read");

    a_write_other_code: assert property (
        @(posedge clk) disable iff (rst)
        host.writeByte && !host.clearFaults && evt == '0
        && host.code != PTS_CMD_TEMP_STATUS
        && host.code != PTS_CMD_CML_STATUS
        |=> tempStatus == $past(tempStatus)
        && cmlStatus == $past(cmlStatus))
        else $error("write to other code changed flags");

    a_temp_no_spill: assert property (
        @(posedge clk) disable iff (rst)
        host.writeByte && !host.clearFaults && evt == '0
        && host.code == PTS_CMD_TEMP_STATUS
        |=> cmlStatus == $past(cmlStatus))
        else $error("temperature write changed link_error_flag flags");

    a_zero_write_holds: assert property (
        @(posedge clk) disable iff (rst)
        host.writeByte && !host.clearFaults
        && host.data == 8'h00 && evt == '0
        |=> tempStatus == $past(tempStatus)
        && cmlStatus == $past(cmlStatus))
        else $error("zero write changed flags");

    a_cml_latch_holds: assert property (
        @(posedge clk) disable iff (rst)
        cmlStatus[PTS_BIT_PEC] && !host.clearFaults
        && !host.writeByte
        |=> cmlStatus[PTS_BIT_PEC])
        else $error("link_error_flag flag dropped without clear");

    a_reset_clears: assert property (
        @(posedge clk)
        $past(rst)
        |-> tempStatus == 8'h00 && cmlStatus == 8'h00
        && !cmlSummary && !alertRequest && !readValid)
        else $error("outputs not cleared by reset");

endmodule : pts_status_regs

/* File: sim/pts_host_model.sv */
// host model issuing status byte accesses
`timescale 1ns/10ps
module pts_host_model (
    input  wire logic             clk,
    output pts_pkg::pts_host_type host
);
    import pts_pkg::*;
    initial host = '0;
    // kind: write, read, clear-faults; one-cycle strobe
    task automatic access(input logic [2:0] kind, input logic [7:0] code,
                          input logic [7:0] data);
        host <= '{kind[2], kind[1], kind[0], code, data};
        @(posedge clk);
        host <= '0;
    endtask : access
endmodule : pts_host_model

/* File: sim/pmbus_temp_cml_status_tb.sv */
// self-checking bench for the status byte block
`timescale 1ns/10ps
module pmbus_temp_cml_status_tb;
    import pts_pkg::*;
    logic          clk = 0;
    logic          rst = 1;
    pts_event_type evt = '0;
    pts_host_type  host;
    logic          loopFollower = 1;
    logic [7:0]    tMask = 8'h00;
    logic [7:0]    cMask = 8'h00;
    logic [7:0]    rdData, tStat, cStat;
    logic          rdValid, summ, alert;
    int            fails = 0;
    int            samplesChecked = 0;
    // event pattern, expected temperature byte, expected cml byte
    logic [24:0]   rows [9] = '{{9'h100, 8'h80, 8'h00}, {9'h080, 8'h40, 8'h00},
        {9'h040, 8'h00, 8'h80}, {9'h020, 8'h00, 8'h40},
        {9'h010, 8'h00, 8'h20}, {9'h008, 8'h00, 8'h10},
        {9'h004, 8'h00, 8'h08}, {9'h002, 8'h00, 8'h02},
        {9'h001, 8'h00, 8'h02}};
    always #10 clk = ~clk;
    pts_status_regs pts_status_regs_i (.clk(clk), .rst(rst), .evt(evt),
        .host(host), .loopFollower(loopFollower), .tempAlertMask(tMask),
        .cmlAlertMask(cMask), .readData(rdData), .readValid(rdValid),
        .tempStatus(tStat), .cmlStatus(cStat), .cmlSummary(summ),
        .alertRequest(alert));
    pts_host_model pts_host_model_i (.clk(clk), .host(host));
    task automatic chk(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
        samplesChecked++;
        if (got !== exp) begin
            fails++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic pulse(input logic [8:0] e);
        @(posedge clk);
        evt <= e;
        @(posedge clk);
        evt <= '0;
        repeat (2) @(posedge clk);
        #1;
    endtask : pulse
    task automatic hostDo(input logic [2:0] k, input logic [7:0] c, d);
        @(posedge clk);
        pts_host_model_i.access(k, c, d);
        #1;
    endtask : hostDo
    task automatic rd(input logic [7:0] c, input logic [7:0] exp);
        hostDo(3'b010, c, 8'h00);
        chk("read valid", 8'h01, {7'h00, rdValid});
        chk("read data", exp, rdData);
    endtask : rd
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", samplesChecked, fails);
        if (fails == 0 && samplesChecked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : print_verdict
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        #1;
        chk("reset flags", 8'h00, tStat | cStat);
        for (int i = 0; i < 9; i++) begin
            pulse(rows[i][24:16]);
            chk("temp flags", rows[i][15:8], tStat);
            chk("cml flags", rows[i][7:0], cStat);
            chk("summary", {7'h00, |rows[i][7:0]}, {7'h00, summ});
            chk("alert", 8'h01, {7'h00, alert});
            rd(PTS_CMD_TEMP_STATUS, rows[i][15:8]);
            rd(PTS_CMD_CML_STATUS, rows[i][7:0]);
            hostDo(3'b100, (rows[i][15:8] != 8'h00) ? PTS_CMD_TEMP_STATUS
                   : PTS_CMD_CML_STATUS, 8'hFF);
            chk("after clear", 8'h00, tStat | cStat | {7'h00, summ});
            $display("row %0d done", i);
        end
        // zero and read-only writes must leave latched flags alone
        pulse(9'h1FF);
        hostDo(3'b100, PTS_CMD_CML_STATUS, 8'h05);
        hostDo(3'b100, PTS_CMD_TEMP_STATUS, 8'h3F);
        hostDo(3'b100, PTS_CMD_CML_STATUS, 8'h00);
        chk("temp kept", 8'hC0, tStat);
        chk("cml kept", 8'hFA, cStat);
        hostDo(3'b001, 8'h00, 8'h00);
        chk("clear faults", 8'h00, tStat | cStat | {7'h00, summ});
        $display("clear test done");
        @(posedge clk);
        evt <= 9'h010;
        pts_host_model_i.access(3'b100, PTS_CMD_CML_STATUS, 8'h20);
        evt <= '0;
        #1;
        chk("set beats clear", 8'h20, cStat);
        hostDo(3'b001, 8'h00, 8'h00);
        $display("set beats clear test done");
        @(posedge clk);
        tMask <= 8'hFF;
        cMask <= 8'hFF;
        loopFollower <= 1'b0;
        pulse(9'h101);
        chk("masked temp", 8'h80, tStat);
        chk("non-follower", 8'h00, cStat);
        chk("masked alert", 8'h00, {7'h00, alert});
        rd(8'h7F, 8'h00);
        $display("mask test done");
        pulse(9'h1FF);
        @(posedge clk);
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        #1;
        chk("mid reset", 8'h00, tStat | cStat | {7'h00, summ});
        rd(PTS_CMD_CML_STATUS, 8'h00);
        $display("reset test done");
        print_verdict();
    end
endmodule : pmbus_temp_cml_status_tb
